// *** rtl/slsm_pkg.sv ***
// package: register map, field layout and carriers for the link monitor
package slsm_pkg;

  // ****************
  // register offsets
  // ****************
  localparam logic [7:0] OFF_RECONFIG = 8'h0C;
  localparam logic [7:0] OFF_LINK_STATUS = 8'h10;
  localparam logic [7:0] OFF_CRATE_TAG = 8'h20;
  localparam logic [7:0] OFF_MON_CTRL = 8'h30;
  localparam logic [7:0] OFF_MON_STATUS = 8'h34;
  localparam logic [7:0] OFF_MON_MASK = 8'h40;
  localparam logic [7:0] OFF_MON_VALUE = 8'h60;
  localparam logic [7:0] OFF_MON_THRESH = 8'h80;
  localparam logic [7:0] OFF_MON_CAPTURE = 8'h90;

  // ****************
  // sizes and reset values
  // ****************
  localparam int LANES = 4;
  localparam int TAG_W = 16;
  localparam int LAT_W = 16;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] RECONFIG_RESET = 32'h0000_0000;
  localparam logic [LAT_W-1:0] LAT_ZERO = 16'h0000;
  localparam logic [LAT_W-1:0] LAT_ONE = 16'h0001;
  localparam logic [LAT_W-1:0] LAT_MAX = 16'hFFFF;
  // tick length of the latency counter, in ns
  localparam int LAT_TICK_NS = 4;

  // ****************
  // field positions
  // ****************
  localparam int MON_EN_BIT = 0;
  localparam int MON_RDY_BIT = 0;
  localparam int MON_CRC_LSB = 8;
  localparam int MON_LAT_LSB = 16;
  localparam int RC_WDATA_LSB = 0;
  localparam int RC_ADDR_LSB = 16;
  localparam int RC_ADDR_W = 8;
  localparam int RC_STROBE_BIT = 24;
  localparam int RC_SEL_A_BIT = 25;
  localparam int RC_SEL_B_BIT = 26;

  // ****************
  // carriers
  // ****************
  typedef struct packed {
    logic [LANES-1:0] lane_fatal_fault;
    logic [LANES-1:0] lane_trained;
    logic [LANES-1:0] rx_invert_flag;
    logic channel_trained;
    logic tx_pll_locked;
  } slsm_xcvr_type;

  typedef struct packed {
    logic reconfig_select_b;
    logic reconfig_select_a;
    logic reconfig_write_strobe;
    logic [RC_ADDR_W-1:0] reconfig_port_addr;
    logic [15:0] reconfig_port_wdata;
  } slsm_reconfig_type;

  typedef struct packed {
    logic [TAG_W-1:0] source_crate_tag;
    logic [LAT_W-1:0] latency;
    logic [LANES-1:0] lane_check_pass;
    logic [31:0] capture;
    logic ready;
  } slsm_snap_type;

  typedef enum logic [3:0] {
    SLSM_IDLE = 4'b0001,
    SLSM_ARMED = 4'b0010,
    SLSM_WAIT = 4'b0100,
    SLSM_DONE = 4'b1000
  } slsm_mon_state_type;

endpackage

// *** rtl/slsm_sync.sv ***
// two-flop level synchroniser, width set by parameter
`timescale 1ns/10ps
module slsm_sync #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input wire logic clk,
  input wire logic rst_n,
  // level in, level out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// *** rtl/slsm_top.sv ***
// link status and data monitor register bank
`timescale 1ns/10ps
// Function
// [R1] per-lane fatal fault flag sets on hard error, holds until link reset
// [R2] per-lane receive inversion flag reports detected polarity inversion
// [R3] transmit pll lock flag reads 0 unlocked, 1 locked
// [R4] receive data indicator reads 0 while data arrives, 1 otherwise
// [R5] lower 16 bits of first received word captured as crate tag
// [R6] crate tag refreshed on every idle to data transition of the link
// [R7] monitor runs only while enabled; software disables it before readout
// [R8] monitor ready bit reads 1 once monitor triggered and data captured
// [R9] per-lane checksum pass bits from the most recent sync frame
// [R10] sync to first word latency in ticks, upper half of monitor status
// [R11] software leaves reconfiguration control word unchanged; fields laid out
// [R12] debug mask, value, threshold and data registers, 32 bits, reset zero
// [R13] reads have no side effect; trained bits follow live lane state
module slsm_top
(
  // host clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host register port
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  // link reset request, host domain
  input wire logic link_reset,
  // transceiver, link domain
  input wire logic link_clk,
  input wire logic [slsm_pkg::LANES-1:0] lane_hard_err,
  input wire logic [slsm_pkg::LANES-1:0] lane_up,
  input wire logic [slsm_pkg::LANES-1:0] rx_pol_inverted,
  input wire logic chan_up,
  input wire logic tx_pll_lock,
  input wire logic rx_valid,
  input wire logic [31:0] rx_data,
  input wire logic crc_strobe,
  input wire logic [slsm_pkg::LANES-1:0] crc_pass,
  // system sync pin, active low
  input wire logic sync_n,
  // reconfiguration port fields
  output slsm_pkg::slsm_reconfig_type reconfig_ctrl
);
  import slsm_pkg::*;

  // ****************
  // host registers
  // ****************
  logic [31:0] reconfig_word;
  logic mon_enable;
  logic [31:0] mon_mask;
  logic [31:0] mon_value;
  logic [31:0] mon_thresh;
  logic [31:0] next_rdata;
  logic wr_hit;

  assign wr_hit = reg_sel && reg_wr;

  // field layout kept for the transceiver port (see [R11])
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reconfig_word <= RECONFIG_RESET;
    end else if (wr_hit && reg_addr == OFF_RECONFIG) begin
      reconfig_word <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reconfig_ctrl <= '0;
    end else begin
      reconfig_ctrl <= slsm_reconfig_type'(
        reconfig_word[RC_SEL_B_BIT:RC_WDATA_LSB]); // see [R11]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mon_enable <= 1'b0;
    end else if (wr_hit && reg_addr == OFF_MON_CTRL) begin
      mon_enable <= reg_wdata[MON_EN_BIT]; // see [R7]
    end
  end

  // debug storage only; nothing in the block consumes it (see [R12])
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mon_mask <= RESET_WORD;
      mon_value <= RESET_WORD;
      mon_thresh <= RESET_WORD;
    end else if (wr_hit) begin
      if (reg_addr == OFF_MON_MASK) begin
        mon_mask <= reg_wdata;
      end
      if (reg_addr == OFF_MON_VALUE) begin
        mon_value <= reg_wdata;
      end
      if (reg_addr == OFF_MON_THRESH) begin
        mon_thresh <= reg_wdata;
      end
    end
  end

  // ****************
  // reset into the link domain
  // ****************
  logic link_rst_n;
  slsm_sync #(.W(1)) u_rst_sync (
    .clk(link_clk),
    .rst_n(1'b1),
    .d(rst_n),
    .q(link_rst_n)
  );

  // ****************
  // transceiver levels into the host domain
  // ****************
  localparam int LVL_W = 3 * LANES + 3;
  logic [LVL_W-1:0] lvl_link;
  logic [LVL_W-1:0] lvl_host;
  logic [LANES-1:0] err_s;
  logic [LANES-1:0] up_s;
  logic [LANES-1:0] pol_s;
  logic chan_s;
  logic lock_s;
  logic valid_s;

  assign lvl_link = {lane_hard_err, lane_up, rx_pol_inverted,
                     chan_up, tx_pll_lock, rx_valid};
  assign {err_s, up_s, pol_s, chan_s, lock_s, valid_s} = lvl_host;

  slsm_sync #(.W(LVL_W)) u_lvl_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(lvl_link),
    .q(lvl_host)
  );

  slsm_xcvr_type xcvr;
  logic rx_data_absent_n;
  // fault is sticky; a new error in the reset cycle still wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xcvr <= '0;
      rx_data_absent_n <= 1'b0;
    end else begin
      xcvr.lane_fatal_fault <= (link_reset ? '0 : xcvr.lane_fatal_fault)
                               | err_s; // see [R1]
      xcvr.lane_trained <= up_s; // see [R13]
      xcvr.rx_invert_flag <= pol_s; // see [R2]
      xcvr.channel_trained <= chan_s; // see [R13]
      xcvr.tx_pll_locked <= lock_s; // see [R3]
      rx_data_absent_n <= !valid_s; // see [R4]
    end
  end

  // ****************
  // link-domain monitor
  // ****************
  logic en_link;
  logic sync_n_s;
  logic sync_n_d;
  logic valid_d;
  slsm_mon_state_type mon_state;
  logic [LAT_W-1:0] lat_cnt;
  slsm_snap_type snap;

  slsm_sync #(.W(1)) u_en_sync (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .d(mon_enable),
    .q(en_link)
  );

  // sync is a pin, so it passes two flops first
  slsm_sync #(.W(1)) u_pin_sync (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .d(sync_n),
    .q(sync_n_s)
  );

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      sync_n_d <= 1'b1;
      valid_d <= 1'b0;
    end else begin
      sync_n_d <= sync_n_s;
      valid_d <= rx_valid;
    end
  end

  // idle to data edge reloads the tag (see [R5]) (see [R6])
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      snap.source_crate_tag <= '0;
    end else if (rx_valid && !valid_d) begin
      snap.source_crate_tag <= rx_data[TAG_W-1:0];
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      snap.lane_check_pass <= '0;
    end else if (crc_strobe) begin
      snap.lane_check_pass <= crc_pass; // see [R9]
    end
  end

  // held in SLSM_IDLE while disabled so a readout sees stable data
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      mon_state <= SLSM_IDLE;
    end else if (!en_link) begin
      mon_state <= SLSM_IDLE;
    end else begin
      case (mon_state)
        SLSM_IDLE: mon_state <= SLSM_ARMED; // see [R7]
        SLSM_ARMED: begin
          if (sync_n_d && !sync_n_s) begin
            mon_state <= SLSM_WAIT;
          end
        end
        SLSM_WAIT: begin
          if (rx_valid) begin
            mon_state <= SLSM_DONE;
          end
        end
        SLSM_DONE: mon_state <= SLSM_DONE;
        default: mon_state <= SLSM_IDLE;
      endcase
    end
  end

  // saturating tick counter from the sync edge
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      lat_cnt <= LAT_ZERO;
    end else if (mon_state == SLSM_ARMED) begin
      lat_cnt <= LAT_ZERO;
    end else if (mon_state == SLSM_WAIT && lat_cnt != LAT_MAX) begin
      lat_cnt <= lat_cnt + LAT_ONE; // see [R10]
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      snap.latency <= LAT_ZERO;
      snap.capture <= RESET_WORD;
      snap.ready <= 1'b0;
    end else if (mon_state == SLSM_IDLE && en_link) begin
      snap.ready <= 1'b0;
    end else if (mon_state == SLSM_WAIT && en_link && rx_valid) begin
      snap.latency <= lat_cnt; // see [R10]
      snap.capture <= rx_data;
      snap.ready <= 1'b1; // see [R8]
    end
  end

  // ****************
  // snapshot crossing: toggle request, data held until acknowledged
  // ****************
  slsm_snap_type snap_d;
  slsm_snap_type xfer;
  logic dirty;
  logic req_tgl;
  logic ack_link;
  logic busy;

  assign busy = req_tgl != ack_link;

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      snap_d <= '0;
    end else begin
      snap_d <= snap;
    end
  end

  // a change during a transfer is remembered and sent afterwards
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      xfer <= '0;
      dirty <= 1'b0;
      req_tgl <= 1'b0;
    end else if (!busy && (dirty || snap != snap_d)) begin
      xfer <= snap;
      dirty <= 1'b0;
      req_tgl <= !req_tgl;
    end else if (snap != snap_d) begin
      dirty <= 1'b1;
    end
  end

  logic req_host;
  logic req_host_d;
  slsm_snap_type shown;

  slsm_sync #(.W(1)) u_req_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(req_tgl),
    .q(req_host)
  );

  slsm_sync #(.W(1)) u_ack_sync (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .d(req_host_d),
    .q(ack_link)
  );

  // xfer is stable while the request is outstanding
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_host_d <= 1'b0;
      shown <= '0;
    end else begin
      req_host_d <= req_host;
      if (req_host != req_host_d) begin
        shown <= xfer;
      end
    end
  end

  // ****************
  // read path, no side effects (see [R13])
  // ****************
  always_comb begin
    next_rdata = RESET_WORD;
    case (reg_addr)
      OFF_RECONFIG: next_rdata = reconfig_word;
      OFF_LINK_STATUS: next_rdata[15:0] = {1'b0, rx_data_absent_n,
        xcvr.tx_pll_locked, xcvr.channel_trained, xcvr.rx_invert_flag,
        xcvr.lane_trained, xcvr.lane_fatal_fault};
      OFF_CRATE_TAG: begin
        next_rdata[TAG_W-1:0] = shown.source_crate_tag; // see [R5]
      end
      OFF_MON_CTRL: next_rdata[MON_EN_BIT] = mon_enable;
      OFF_MON_STATUS: begin
        next_rdata[MON_RDY_BIT] = shown.ready; // see [R8]
        next_rdata[MON_CRC_LSB +: LANES] = shown.lane_check_pass;
        next_rdata[MON_LAT_LSB +: LAT_W] = shown.latency; // see [R10]
      end
      OFF_MON_MASK: next_rdata = mon_mask;
      OFF_MON_VALUE: next_rdata = mon_value;
      OFF_MON_THRESH: next_rdata = mon_thresh;
      OFF_MON_CAPTURE: next_rdata = shown.capture; // see [R12]
      default: next_rdata = RESET_WORD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= RESET_WORD;
      reg_ack <= 1'b0;
    end else begin
      reg_ack <= reg_sel;
      if (reg_sel && !reg_wr) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule

// *** sim/slsm_far_end.sv ***
// far end model: lane status levels and eight-word frames on the link
`timescale 1ns/10ps
module slsm_far_end (
  // link clock, free running
  input wire logic link_clk,
  // control from the bench
  input wire logic go,
  input wire logic [31:0] word,
  input wire logic [slsm_pkg::LANES-1:0] crc,
  input wire slsm_pkg::slsm_xcvr_type cfg,
  // link side
  output slsm_pkg::slsm_xcvr_type xcvr,
  output logic rx_valid,
  output logic [31:0] rx_data,
  output logic crc_strobe,
  output logic [slsm_pkg::LANES-1:0] crc_pass
);
  import slsm_pkg::*;
  logic go_q = 1'b0;
  logic [3:0] beat = 4'h0;
  initial rx_valid = 1'b0;
  initial rx_data = 32'h0;
  always_ff @(posedge link_clk) begin
    xcvr <= cfg;
    crc_strobe <= beat == 4'h1;
    // pass bits flip outside the strobe so a late load shows up
    crc_pass <= (beat == 4'h1) ? crc : ~crc;
  end
  always @(posedge link_clk) begin
    go_q <= go;
    if (go && !go_q) begin
      beat <= 4'h8;
      rx_valid <= 1'b1;
      rx_data <= word;
    end else if (beat != 4'h0) begin
      beat <= beat - 4'h1;
      rx_valid <= beat != 4'h1;
      rx_data <= (beat != 4'h1) ? rx_data + 32'h1 : ~rx_data;
    end else begin
      // idle data keeps toggling: a stale word must not look held
      rx_data <= ~rx_data;
    end
  end
endmodule

// *** sim/slsm_top_props.sv ***
// checker for the host register port of the link monitor
`timescale 1ns/10ps
module slsm_top_props (
  // host clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host register port
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ack,
  // reconfiguration fields
  input wire slsm_pkg::slsm_reconfig_type reconfig_ctrl
);
  import slsm_pkg::*;
  logic rd_req;
  logic wr_rc;
  logic mapped;
  assign rd_req = reg_sel && !reg_wr;
  assign wr_rc = reg_sel && reg_wr && reg_addr == OFF_RECONFIG;
  assign mapped = reg_addr inside {OFF_RECONFIG, OFF_LINK_STATUS,
    OFF_CRATE_TAG, OFF_MON_CTRL, OFF_MON_STATUS, OFF_MON_MASK,
    OFF_MON_VALUE, OFF_MON_THRESH, OFF_MON_CAPTURE};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ack_follows_a: assert property (reg_sel |=> reg_ack)
    else $error("access not acknowledged");
  ack_only_a: assert property (!reg_sel |=> !reg_ack)
    else $error("ack without access");
  rdata_hold_a: assert property (!rd_req |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (rd_req && !mapped
    |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  rc_follow_a: assert property (wr_rc |-> ##2
    reconfig_ctrl == $past(reg_wdata[26:0], 2))
    else $error("reconfig fields do not follow write");
  rc_stable_a: assert property (!wr_rc [*2]
    |=> $stable(reconfig_ctrl))
    else $error("reconfig fields changed unasked");
  status_resv_a: assert property (rd_req && reg_addr == OFF_LINK_STATUS
    |=> reg_rdata[31:15] == 17'h0)
    else $error("status reserved bits set");
  tag_resv_a: assert property (rd_req && reg_addr == OFF_CRATE_TAG
    |=> reg_rdata[31:16] == 16'h0)
    else $error("tag upper half set");
  mstat_resv_a: assert property (rd_req && reg_addr == OFF_MON_STATUS
    |=> reg_rdata[15:12] == 4'h0 && reg_rdata[7:1] == 7'h0)
    else $error("monitor status reserved bits set");
  mctrl_resv_a: assert property (rd_req && reg_addr == OFF_MON_CTRL
    |=> reg_rdata[31:1] == 31'h0)
    else $error("monitor control reserved bits set");
endmodule

bind slsm_top slsm_top_props props_i (.clk(clk), .rst_n(rst_n),
  .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
  .reconfig_ctrl(reconfig_ctrl));

// *** sim/test_slsm_top.sv ***
// self-checking bench for the link status and monitor register bank
`timescale 1ns/10ps
module test_slsm_top;
  import slsm_pkg::*;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_sel = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic reg_ack;
  logic link_reset = 1'b0;
  logic sync_n = 1'b1;
  logic go = 1'b0;
  logic [31:0] word = 32'h0;
  logic [LANES-1:0] crc = 4'h0;
  slsm_xcvr_type cfg = '0;
  slsm_xcvr_type xcvr;
  logic rx_valid;
  logic [31:0] rx_data;
  logic crc_strobe;
  logic [LANES-1:0] crc_pass;
  slsm_reconfig_type reconfig_ctrl;
  logic [31:0] rd;
  logic [7:0] offs [9] = '{OFF_RECONFIG, OFF_CRATE_TAG, OFF_MON_CTRL,
    OFF_MON_STATUS, OFF_MON_MASK, OFF_MON_VALUE, OFF_MON_THRESH,
    OFF_MON_CAPTURE, 8'h44};
  int n_fail = 0;
  int num_checks = 0;
  always #25 clk = ~clk;
  always #62.5 link_clk = ~link_clk;
  slsm_top dut (.clk(clk), .rst_n(rst_n), .reg_sel(reg_sel),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .link_reset(link_reset),
    .link_clk(link_clk), .lane_hard_err(xcvr.lane_fatal_fault),
    .lane_up(xcvr.lane_trained), .rx_pol_inverted(xcvr.rx_invert_flag),
    .chan_up(xcvr.channel_trained), .tx_pll_lock(xcvr.tx_pll_locked),
    .rx_valid(rx_valid), .rx_data(rx_data), .crc_strobe(crc_strobe),
    .crc_pass(crc_pass), .sync_n(sync_n), .reconfig_ctrl(reconfig_ctrl));
  slsm_far_end far_i (.link_clk(link_clk), .go(go), .word(word),
    .crc(crc), .cfg(cfg), .xcvr(xcvr), .rx_valid(rx_valid),
    .rx_data(rx_data), .crc_strobe(crc_strobe), .crc_pass(crc_pass));
  // ****************
  // tasks
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic access(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge clk);
    reg_sel <= 1'b1;
    reg_wr <= wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_sel <= 1'b0;
    // ack and read data are settled by the falling edge
    @(negedge clk);
    rd = reg_rdata;
    check({31'h0, reg_ack}, 32'h1);
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    access(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  // link changes reach the host view a few cycles late
  task automatic settle;
    repeat (6) @(posedge link_clk);
    repeat (4) @(posedge clk);
  endtask
  task automatic frame(input logic [31:0] w);
    @(posedge clk);
    word <= w;
    go <= 1'b1;
    settle();
    go <= 1'b0;
    settle();
  endtask
  task automatic end_of_test;
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    n_fail++;
    end_of_test();
  end
  // ****************
  // sequence
  // ****************
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    foreach (offs[i]) rd_chk(offs[i], 32'h0);
    rd_chk(OFF_LINK_STATUS, 32'h0000_4000);
    for (int i = 1; i < 9; i++) begin
      if (i != 2) begin
        access(1'b1, offs[i], 32'hC35A_0F00);
        rd_chk(offs[i], (i > 3 && i < 7) ? 32'hC35A_0F00 : 32'h0);
      end
    end
    access(1'b1, OFF_RECONFIG, 32'h07AB_CDEF);
    rd_chk(OFF_RECONFIG, 32'h07AB_CDEF);
    check({5'h0, reconfig_ctrl}, 32'h07AB_CDEF);
    access(1'b1, OFF_RECONFIG, 32'h0);
    cfg <= '{4'h5, 4'hF, 4'hA, 1'b1, 1'b1};
    settle();
    rd_chk(OFF_LINK_STATUS, 32'h0000_7AF5);
    cfg.lane_fatal_fault <= 4'h0;
    settle();
    rd_chk(OFF_LINK_STATUS, 32'h0000_7AF5);
    rd_chk(OFF_LINK_STATUS, 32'h0000_7AF5);
    @(posedge clk);
    link_reset <= 1'b1;
    @(posedge clk);
    link_reset <= 1'b0;
    settle();
    rd_chk(OFF_LINK_STATUS, 32'h0000_7AF0);
    cfg.lane_trained <= 4'h6;
    cfg.channel_trained <= 1'b0;
    settle();
    rd_chk(OFF_LINK_STATUS, 32'h0000_6A60);
    access(1'b1, OFF_MON_CTRL, 32'h1);
    rd_chk(OFF_MON_CTRL, 32'h1);
    settle();
    rd_chk(OFF_MON_STATUS, 32'h0);
    crc <= 4'h6;
    word <= 32'hA5C3_1234;
    sync_n <= 1'b0;
    repeat (40) @(posedge link_clk);
    @(posedge clk);
    go <= 1'b1;
    repeat (2) @(posedge link_clk);
    repeat (4) @(posedge clk);
    rd_chk(OFF_LINK_STATUS, 32'h0000_2A60);
    settle();
    go <= 1'b0;
    sync_n <= 1'b1;
    settle();
    access(1'b1, OFF_MON_CTRL, 32'h0);
    access(1'b0, OFF_MON_STATUS, 32'h0);
    check({16'h0, rd[15:0]}, 32'h0000_0601);
    check({31'h0, rd[31:16] > 16'h21 && rd[31:16] < 16'h2F},
      32'h1);
    rd_chk(OFF_CRATE_TAG, 32'h0000_1234);
    rd_chk(OFF_MON_CAPTURE, 32'hA5C3_1234);
    frame(32'h0BAD_5678);
    rd_chk(OFF_CRATE_TAG, 32'h0000_5678);
    rd_chk(OFF_MON_CAPTURE, 32'hA5C3_1234);
    access(1'b1, OFF_MON_CTRL, 32'h1);
    settle();
    access(1'b0, OFF_MON_STATUS, 32'h0);
    check({31'h0, rd[0]}, 32'h0);
    end_of_test();
  end
endmodule
